// file: brv_pkg.sv
// brv_pkg: constants and carrier types for the buck rail mode/vid block
// assumes: included ahead of every other file of the block
`default_nettype none

package brv_pkg;

    // register offsets
    localparam logic [7:0] ADDR_VID_OVR = 8'h33;
    localparam logic [7:0] ADDR_GFX_CTRL = 8'h36;
    localparam logic [7:0] ADDR_MEM_CTRL = 8'h37;
    localparam logic [7:0] ADDR_MEM_CUR = 8'h3c;

    // values after reset
    localparam logic [7:0] RST_CTRL = 8'h04;
    localparam logic [7:0] RST_VID_OVR = 8'h7f;
    localparam logic [7:0] RST_MEM_CUR = 8'h00;

    // field positions and widths
    localparam int STATE_LSB = 0;
    localparam int EXIT_LSB = 3;
    localparam int FLD_W = 3;
    localparam int CTRL_W = 6;
    localparam int OVR_BIT = 7;
    localparam int VID_W = 7;

    // operating state codes
    localparam logic [2:0] ST_OFF = 3'h4;
    localparam logic [2:0] ST_PFM = 3'h5;
    localparam logic [2:0] ST_SKIP = 3'h6;
    localparam logic [2:0] ST_PWM = 3'h7;

    // output step of one vid code, in microvolts
    localparam int VID_STEP_UV = 12500;

    // pin synchroniser depth
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic off;
        logic pfm;
        logic skip;
        logic pwm;
    } brv_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } brv_req_t;

    localparam brv_mode_t MODE_OFF = '{off: 1'b1, pfm: 1'b0, skip: 1'b0,
                                       pwm: 1'b0};

    function automatic brv_mode_t brv_decode(input logic [2:0] st);
        brv_mode_t m;
        m.off = (st == ST_OFF);
        m.pfm = (st == ST_PFM);
        m.skip = (st == ST_SKIP);
        m.pwm = (st == ST_PWM);
        return m;
    endfunction : brv_decode

endpackage : brv_pkg

`default_nettype wire

// file: brv_rail.sv
// brv_rail: one buck rail control register, standby-exit copy, mode decode,
// discharge and over-current fault/limit
// assumes: all inputs already on clk; exit_pulse is one cycle wide
`default_nettype none

module brv_rail
    import brv_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    input wire logic exit_pulse,
    input wire logic oc,
    output logic [CTRL_W-1:0] ctrl_r,
    output brv_mode_t mode_r,
    output logic discharge_r,
    output logic limit_r,
    output logic fault_r
);

    logic [FLD_W-1:0] exit_fld;
    logic exit_copy;
    logic [CTRL_W-1:0] ctrl_wr;
    logic [CTRL_W-1:0] ctrl_nxt;
    brv_mode_t mode_nxt;

    assign exit_fld = ctrl_r[EXIT_LSB +: FLD_W];
    // codes 4..7 copy, 0..3 do not
    assign exit_copy = exit_pulse & exit_fld[2];
    // bits 7:6 never stored
    assign ctrl_wr = wr_en ? wdata[CTRL_W-1:0] : ctrl_r;
    assign ctrl_nxt = exit_copy ? {ctrl_wr[CTRL_W-1:FLD_W], exit_fld}
                                : ctrl_wr;
    assign mode_nxt = brv_decode(ctrl_nxt[STATE_LSB +: FLD_W]);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= RST_CTRL[CTRL_W-1:0];
            mode_r <= MODE_OFF;
            discharge_r <= 1'b1;
            limit_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else if (ce)
        begin
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            discharge_r <= mode_nxt.off;
            limit_r <= oc & ~mode_nxt.off;
            fault_r <= oc;
        end
    end

    property p_exit_copy;
        @(posedge clk) disable iff (!rst_n)
        ce && exit_copy |=> ctrl_r[2:0] == $past(exit_fld);
    endproperty
    a_exit_copy: assert property (p_exit_copy)
        else $error("exit state not copied");

    property p_no_copy;
        @(posedge clk) disable iff (!rst_n)
        ce && exit_pulse && !exit_fld[2] && !wr_en |=> $stable(ctrl_r);
    endproperty
    a_no_copy: assert property (p_no_copy)
        else $error("control changed on do-not-copy code");

    property p_discharge;
        @(posedge clk) disable iff (!rst_n)
        discharge_r == (ctrl_r[2:0] == ST_OFF);
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge does not follow off state");

    property p_mode_decode;
        @(posedge clk) disable iff (!rst_n)
        mode_r.pwm == (ctrl_r[2:0] == ST_PWM) &&
        mode_r.pfm == (ctrl_r[2:0] == ST_PFM) &&
        (ctrl_r[2] || mode_r == '0);
    endproperty
    a_mode_decode: assert property (p_mode_decode)
        else $error("mode decode wrong");

    property p_fault;
        @(posedge clk) disable iff (!rst_n)
        ce && oc |=> fault_r && (limit_r || discharge_r);
    endproperty
    a_fault: assert property (p_fault)
        else $error("over-current not flagged");

endmodule : brv_rail

`default_nettype wire

// file: brv_top.sv
// brv_top: graphics and memory buck rail control/status register bank
// assumes: req comes from the spi front end on clk; pins are asynchronous
`default_nettype none

module brv_top
    import brv_pkg::*;
#(
    parameter int CUR_W = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire brv_req_t req,
    output logic [7:0] rdata_r,
    output logic rvalid_r,
    input wire logic standby_exit_pin,
    input wire logic [VID_W-1:0] voltage_id_code,
    input wire logic gfx_vid_latch,
    input wire logic gfx_oc,
    input wire logic mem_oc,
    input wire logic mem_cur_valid,
    input wire logic [CUR_W-1:0] mem_cur_data,
    output brv_mode_t gfx_mode_r,
    output brv_mode_t mem_mode_r,
    output logic gfx_discharge_r,
    output logic mem_discharge_r,
    output logic gfx_limit_r,
    output logic mem_limit_r,
    output logic graphics_rail_fault_r,
    output logic memory_rail_fault_r,
    output logic regulator_fault_irq_r,
    output logic [VID_W-1:0] graphics_rail_voltage_code_r
);

    localparam int PIN_W = VID_W + 4;

    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_sync_r;
    logic exit_d_r;
    logic [VID_W-1:0] pin_code_r;
    logic [7:0] vid_ovr_r;
    logic [CUR_W-1:0] mem_cur_r;
    logic [CTRL_W-1:0] gfx_ctrl;
    logic [CTRL_W-1:0] mem_ctrl;

    logic exit_s;
    logic latch_s;
    logic gfx_oc_s;
    logic mem_oc_s;
    logic [VID_W-1:0] vid_s;
    logic exit_pulse;
    logic wr_vid;
    logic wr_gfx;
    logic wr_mem;
    logic [7:0] rd_mux;
    logic [VID_W-1:0] code_nxt;

    assign {exit_s, latch_s, gfx_oc_s, mem_oc_s, vid_s} = pin_sync_r;
    assign exit_pulse = exit_s & ~exit_d_r;

    // register decode
    assign wr_vid = req.wr && req.addr == ADDR_VID_OVR;
    assign wr_gfx = req.wr && req.addr == ADDR_GFX_CTRL;
    assign wr_mem = req.wr && req.addr == ADDR_MEM_CTRL;

    assign rd_mux = (req.addr == ADDR_VID_OVR) ? vid_ovr_r :
                    (req.addr == ADDR_GFX_CTRL) ? {2'h0, gfx_ctrl} :
                    (req.addr == ADDR_MEM_CTRL) ? {2'h0, mem_ctrl} :
                    (req.addr == ADDR_MEM_CUR) ? 8'(mem_cur_r) :
                    8'h00;

    // applied code: register when override set, else latched pins
    assign code_nxt = vid_ovr_r[OVR_BIT] ? vid_ovr_r[VID_W-1:0]
                                         : pin_code_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            exit_d_r <= 1'b0;
        end
        else if (ce)
        begin
            pin_meta_r <= {standby_exit_pin, gfx_vid_latch, gfx_oc, mem_oc,
                           voltage_id_code};
            pin_sync_r <= pin_meta_r;
            exit_d_r <= exit_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_code_r <= RST_VID_OVR[VID_W-1:0];
            vid_ovr_r <= RST_VID_OVR;
            graphics_rail_voltage_code_r <= RST_VID_OVR[VID_W-1:0];
        end
        else if (ce)
        begin
            if (latch_s)
                pin_code_r <= vid_s;
            if (wr_vid)
                vid_ovr_r <= req.wdata;
            graphics_rail_voltage_code_r <= code_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_cur_r <= RST_MEM_CUR[CUR_W-1:0];
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            regulator_fault_irq_r <= 1'b0;
        end
        else if (ce)
        begin
            if (mem_cur_valid)
                mem_cur_r <= mem_cur_data;
            rdata_r <= req.rd ? rd_mux : 8'h00;
            rvalid_r <= req.rd;
            regulator_fault_irq_r <= gfx_oc_s | mem_oc_s;
        end
    end

    brv_rail u_gfx (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(wr_gfx),
        .wdata(req.wdata),
        .exit_pulse(exit_pulse),
        .oc(gfx_oc_s),
        .ctrl_r(gfx_ctrl),
        .mode_r(gfx_mode_r),
        .discharge_r(gfx_discharge_r),
        .limit_r(gfx_limit_r),
        .fault_r(graphics_rail_fault_r)
    );

    brv_rail u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(wr_mem),
        .wdata(req.wdata),
        .exit_pulse(exit_pulse),
        .oc(mem_oc_s),
        .ctrl_r(mem_ctrl),
        .mode_r(mem_mode_r),
        .discharge_r(mem_discharge_r),
        .limit_r(mem_limit_r),
        .fault_r(memory_rail_fault_r)
    );

    sequence s_rd_req;
        ce && req.rd && !req.wr;
    endsequence

    sequence s_rd_ans(logic [7:0] v);
        rvalid_r && rdata_r == v;
    endsequence

    property p_read_back;
        @(posedge clk) disable iff (!rst_n)
        s_rd_req |=> s_rd_ans($past(rd_mux));
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read data mismatch");

    property p_ctrl_reserved;
        @(posedge clk) disable iff (!rst_n)
        ce && req.rd && (req.addr == ADDR_GFX_CTRL ||
                         req.addr == ADDR_MEM_CTRL) |=> rdata_r[7:6] == 2'h0;
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved)
        else $error("reserved control bits not zero");

    property p_mem_write;
        @(posedge clk) disable iff (!rst_n)
        ce && wr_mem && !exit_pulse |=> mem_ctrl == $past(req.wdata[5:0]);
    endproperty
    a_mem_write: assert property (p_mem_write)
        else $error("memory control write lost");

    property p_vid_override;
        @(posedge clk) disable iff (!rst_n)
        ce && vid_ovr_r[OVR_BIT] && !wr_vid |=>
            graphics_rail_voltage_code_r == $past(vid_ovr_r[6:0]);
    endproperty
    a_vid_override: assert property (p_vid_override)
        else $error("override code not applied");

    property p_vid_pins;
        @(posedge clk) disable iff (!rst_n)
        ce && !vid_ovr_r[OVR_BIT] && !wr_vid |=>
            graphics_rail_voltage_code_r == $past(pin_code_r) &&
            $stable(vid_ovr_r);
    endproperty
    a_vid_pins: assert property (p_vid_pins)
        else $error("pin code not tracked");

    property p_irq;
        @(posedge clk) disable iff (!rst_n)
        ce && (gfx_oc_s || mem_oc_s) |=> regulator_fault_irq_r;
    endproperty
    a_irq: assert property (p_irq)
        else $error("fault interrupt missing");

    property p_cur;
        @(posedge clk) disable iff (!rst_n)
        ce && mem_cur_valid |=> mem_cur_r == $past(mem_cur_data);
    endproperty
    a_cur: assert property (p_cur)
        else $error("current sample not stored");

endmodule : brv_top

`default_nettype wire

// file: brv_host.sv
// brv_host: host controller model issuing register requests to brv_top
// assumes: one request per cycle, read answer registered on the take edge
`default_nettype none

module brv_host
    import brv_pkg::*;
(
    input wire logic clk,
    output brv_req_t req,
    input wire logic [7:0] rdata_r,
    input wire logic rvalid_r
);
    timeunit 1ns;
    timeprecision 1ns;

    initial req = '0;

    // host sets rail modes and exit fields by register writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        #1;
        d = rdata_r;
        v = rvalid_r;
    endtask : rd
endmodule : brv_host

`default_nettype wire

// file: buck_rail_mode_vid_control_tb.sv
// buck_rail_mode_vid_control_tb: self-checking bench for brv_top
// assumes: brv_pkg, brv_rail, brv_top and brv_host compiled first
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    fails++; $display("BAD %s exp %h got %h", nm, e, g); end end

module buck_rail_mode_vid_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import brv_pkg::*;

    logic clk, rst_n, ce, pin, latch, gfx_oc, mem_oc, cur_v;
    logic [6:0] vid_pins;
    logic [7:0] cur_d, rdata;
    logic rvalid, gfx_dis, mem_dis, gfx_lim, mem_lim, gfx_flt, mem_flt, irq;
    logic [6:0] vcode;
    brv_req_t req;
    brv_mode_t gfx_mode, mem_mode;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;

    brv_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req),
        .rdata_r(rdata), .rvalid_r(rvalid), .standby_exit_pin(pin),
        .voltage_id_code(vid_pins), .gfx_vid_latch(latch),
        .gfx_oc(gfx_oc), .mem_oc(mem_oc), .mem_cur_valid(cur_v),
        .mem_cur_data(cur_d), .gfx_mode_r(gfx_mode), .mem_mode_r(mem_mode),
        .gfx_discharge_r(gfx_dis), .mem_discharge_r(mem_dis),
        .gfx_limit_r(gfx_lim), .mem_limit_r(mem_lim),
        .graphics_rail_fault_r(gfx_flt), .memory_rail_fault_r(mem_flt),
        .regulator_fault_irq_r(irq), .graphics_rail_voltage_code_r(vcode));

    brv_host host (.clk(clk), .req(req), .rdata_r(rdata), .rvalid_r(rvalid));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            test_done;
        end
    end

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, d)
    endtask : rd_chk

    task automatic t_reset;
        #1;
        `CHK("gfx mode", 4'b1000, gfx_mode)
        `CHK("mem discharge", 1'b1, mem_dis)
        `CHK("vid code", 7'h7f, vcode)
        rd_chk(ADDR_GFX_CTRL, 8'h04);
        rd_chk(ADDR_MEM_CTRL, 8'h04);
        rd_chk(ADDR_VID_OVR, 8'h7f);
        rd_chk(8'h40, 8'h00);
    endtask : t_reset

    task automatic t_modes;
        logic [3:0] e;
        for (int c = 0; c < 8; c++)
        begin
            host.wr(ADDR_MEM_CTRL, 8'(c));
            e = (c >= 4) ? (4'b1000 >> (c - 4)) : 4'b0000;
            @(posedge clk);
            #1;
            `CHK("mem mode", e, mem_mode)
            `CHK("mem discharge", (c == 4), mem_dis)
        end
        host.wr(ADDR_MEM_CTRL, 8'hff);
        rd_chk(ADDR_MEM_CTRL, 8'h3f);
    endtask : t_modes

    task automatic exit_pulse;
        @(posedge clk);
        pin <= 1'b1;
        repeat (5) @(posedge clk);
        pin <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : exit_pulse

    task automatic t_exit;
        host.wr(ADDR_GFX_CTRL, 8'h2c);
        host.wr(ADDR_MEM_CTRL, 8'h16);
        exit_pulse;
        `CHK("gfx mode", 4'b0100, gfx_mode)
        `CHK("gfx discharge", 1'b0, gfx_dis)
        `CHK("mem mode", 4'b0010, mem_mode)
        rd_chk(ADDR_GFX_CTRL, 8'h2d);
        host.wr(ADDR_MEM_CTRL, 8'h3c);
        exit_pulse;
        `CHK("mem mode", 4'b0001, mem_mode)
    endtask : t_exit

    task automatic t_vid;
        @(posedge clk);
        vid_pins <= 7'h15;
        latch <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        `CHK("vid code", 7'h15, vcode)
        @(posedge clk);
        latch <= 1'b0;
        vid_pins <= 7'h6a;
        repeat (8) @(posedge clk);
        #1;
        `CHK("vid code", 7'h15, vcode)
        rd_chk(ADDR_VID_OVR, 8'h7f);
        host.wr(ADDR_VID_OVR, 8'haa);
        repeat (4) @(posedge clk);
        #1;
        `CHK("vid code", 7'h2a, vcode)
        host.wr(ADDR_VID_OVR, 8'h2a);
        repeat (4) @(posedge clk);
        #1;
        `CHK("vid code", 7'h15, vcode)
    endtask : t_vid

    task automatic t_fault;
        @(posedge clk);
        mem_oc <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        `CHK("mem fault", 3'b111, {mem_flt, irq, mem_lim})
        `CHK("gfx fault", 1'b0, gfx_flt)
        @(posedge clk);
        mem_oc <= 1'b0;
        gfx_oc <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        `CHK("gfx fault", 3'b111, {gfx_flt, irq, gfx_lim})
        `CHK("mem fault", 1'b0, mem_flt)
        @(posedge clk);
        gfx_oc <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        `CHK("irq", 1'b0, irq)
    endtask : t_fault

    task automatic t_cur;
        @(posedge clk);
        cur_d <= 8'h5a;
        cur_v <= 1'b1;
        @(posedge clk);
        cur_v <= 1'b0;
        cur_d <= 8'ha5;
        rd_chk(ADDR_MEM_CUR, 8'h5a);
    endtask : t_cur

    // write while clock enable is low must be ignored
    task automatic t_ce;
        @(posedge clk);
        ce <= 1'b0;
        host.wr(ADDR_GFX_CTRL, 8'h3f);
        ce <= 1'b1;
        rd_chk(ADDR_GFX_CTRL, 8'h2d);
        `CHK("gfx mode", 4'b0100, gfx_mode)
    endtask : t_ce

    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        pin = 1'b0;
        latch = 1'b0;
        vid_pins = 7'h00;
        gfx_oc = 1'b0;
        mem_oc = 1'b0;
        cur_v = 1'b0;
        cur_d = 8'h00;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_modes;
        t_exit;
        t_vid;
        t_fault;
        t_cur;
        t_ce;
        test_done;
    end
endmodule : buck_rail_mode_vid_control_tb

`default_nettype wire
